/* design/boolean_equation_evaluator.sv */
// What this block does
// - phase A undervoltage flag is 1 while magnitude below pickup, else 0.
// - offers rising edge, falling edge, grouping, NOT, AND and OR on flags.
// - precedence: rising, falling, parentheses, NOT, AND, then OR.
// - several groups per equation, each evaluated then combined.
// - one grouping level only; configuration never nests groups.
// - NOT inverts a single flag or a whole evaluated group.
// - breaker status result 1 means closed, 0 open; input may be inverted.
// - each opto input flag reads 1 energized, 0 de-energized.
// - variable timer runs only while its input equation differs from its output.
// - rising edge gives 1 for exactly one interval on 0 to 1.
// - falling edge gives 1 for exactly one interval on 1 to 0.
// - edge operators apply only to single flags, never to groups.
//
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module boolean_equation_evaluator (
   input  wire logic                          I_SYS_CLK,
   input  wire logic                          I_RSTN,
   input  wire logic                          I_CE,
   input  wire logic                          I_HSEL,
   input  wire logic [31:0]                   I_HADDR,
   input  wire logic [1:0]                    I_HTRANS,
   input  wire logic                          I_HWRITE,
   input  wire logic [2:0]                    I_HSIZE,
   input  wire logic [31:0]                   I_HWDATA,
   input  wire logic                          I_HREADY,
   output logic      [31:0]                   O_HRDATA,
   output logic                               O_HREADYOUT,
   output logic      [1:0]                    O_HRESP,
   input  wire logic [eval_pkg::MAG_W-1:0]    I_VA_MAG,
   input  wire logic [eval_pkg::MAG_W-1:0]    I_VB_MAG,
   input  wire logic [eval_pkg::NUM_OPTO-1:0] I_OPTO,
   output logic      [eval_pkg::NUM_EQ-1:0]   O_RESULT,
   output logic                               O_TIMER_OUT,
   output logic      [eval_pkg::NUM_FLAGS-1:0] O_FLAGS
);
   import eval_pkg::*;

   // bus slave state
   bus_state_e                 bus_state_r;
   logic                       hreadyout_r;
   logic [31:0]                hrdata_r;
   logic [11:0]                addr_r;
   logic                       wr_r;
   // only okay is ever answered, kept in a flop so the port is registered
   logic [1:0]                 hresp_r;

   // software registers
   logic [31:0]                ctrl_r;
   logic [MAG_W-1:0]           uv_pickup_level_r;
   logic [MAG_W-1:0]           ov_pickup_level_r;
   logic [CNT_W-1:0]           timer_pickup_delay_r;
   logic [CNT_W-1:0]           timer_dropout_delay_r;
   logic [NUM_SOFT-1:0]        soft_r;
   logic [NUM_EQ*NUM_GRP-1:0]  ginv_r;
   logic [31:0]                cfg_mem [CFG_WORDS];

   // evaluation state
   logic [NUM_OPTO-1:0]        opto_s1_r;
   logic [NUM_OPTO-1:0]        opto_input_bit_r;
   logic [TICK_W-1:0]          tick_cnt_r;
   logic [NUM_FLAGS-1:0]       flags_prev_r;
   logic [NUM_EQ-1:0]          result_r;
   logic                       variable_timer_output_r;
   logic [CNT_W-1:0]           tmr_cnt_r;

   // ---------------- ahb-lite slave ----------------
   wire        accept    = I_HSEL & I_HTRANS[1] & I_HREADY;
   wire        do_wr     = (bus_state_r == BUS_DATA) & wr_r;
   wire        term_sel  = (addr_r[11:9] == TERM_PAGE) & (addr_r[8:2] < 7'(CFG_WORDS));
   wire [6:0]  term_idx  = addr_r[8:2];
   wire        wr_ctrl   = do_wr & (addr_r == A_CTRL);
   wire        wr_uv     = do_wr & (addr_r == A_UV_PU);
   wire        wr_ov     = do_wr & (addr_r == A_OV_PU);
   wire        wr_tpu    = do_wr & (addr_r == A_TPU);
   wire        wr_tdo    = do_wr & (addr_r == A_TDO);
   wire        wr_soft   = do_wr & (addr_r == A_SOFT);
   wire        wr_ginv   = do_wr & (addr_r == A_GINV);
   wire        wr_term   = do_wr & term_sel;

   wire [31:0] status_word = {11'h000, variable_timer_output_r, result_r, flags_prev_r};
   wire [31:0] rd_data =
      (addr_r == A_CTRL)   ? ctrl_r :
      (addr_r == A_STATUS) ? status_word :
      (addr_r == A_UV_PU)  ? {16'h0000, uv_pickup_level_r} :
      (addr_r == A_OV_PU)  ? {16'h0000, ov_pickup_level_r} :
      (addr_r == A_TPU)    ? {16'h0000, timer_pickup_delay_r} :
      (addr_r == A_TDO)    ? {16'h0000, timer_dropout_delay_r} :
      (addr_r == A_SOFT)   ? {28'h0000000, soft_r} :
      (addr_r == A_GINV)   ? {20'h00000, ginv_r} :
      term_sel             ? cfg_mem[term_idx] : 32'h0000_0000;

   // one wait state keeps read data registered and read-after-write coherent
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         bus_state_r <= BUS_IDLE;
         hreadyout_r <= 1'b1;
         hrdata_r    <= 32'h0000_0000;
         addr_r      <= 12'h000;
         wr_r        <= 1'b0;
         hresp_r     <= HRESP_OKAY;
      end else begin
         hresp_r     <= HRESP_OKAY;
         unique case (bus_state_r)
            BUS_IDLE: begin
               if (accept) begin
                  bus_state_r <= BUS_DATA;
                  hreadyout_r <= 1'b0;
                  addr_r      <= I_HADDR[11:0];
                  wr_r        <= I_HWRITE;
               end
            end
            BUS_DATA: begin
               bus_state_r <= BUS_IDLE;
               hreadyout_r <= 1'b1;
               hrdata_r    <= wr_r ? 32'h0000_0000 : rd_data;
            end
         endcase
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         ctrl_r                <= CTRL_RST;
         uv_pickup_level_r     <= UV_PU_RST;
         ov_pickup_level_r     <= OV_PU_RST;
         timer_pickup_delay_r  <= TPU_RST;
         timer_dropout_delay_r <= TDO_RST;
         soft_r                <= '0;
         ginv_r                <= GINV_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= {31'h0, I_HWDATA[CTRL_EN_BIT]};
         end
         if (wr_uv) begin
            uv_pickup_level_r <= I_HWDATA[MAG_W-1:0];
         end
         if (wr_ov) begin
            ov_pickup_level_r <= I_HWDATA[MAG_W-1:0];
         end
         if (wr_tpu) begin
            timer_pickup_delay_r <= I_HWDATA[CNT_W-1:0];
         end
         if (wr_tdo) begin
            timer_dropout_delay_r <= I_HWDATA[CNT_W-1:0];
         end
         if (wr_soft) begin
            soft_r <= I_HWDATA[NUM_SOFT-1:0];
         end
         if (wr_ginv) begin
            ginv_r <= I_HWDATA[NUM_EQ*NUM_GRP-1:0];
         end
      end
   end

   // term masks: per word {~flag, flag} then {fall, rise}
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         for (int i = 0; i < CFG_WORDS; i++) begin
            cfg_mem[i] <= 32'h0000_0000;
         end
      end else if (wr_term) begin
         cfg_mem[term_idx] <= I_HWDATA;
      end
   end

   // ---------------- flag sources ----------------
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         opto_s1_r        <= '0;
         opto_input_bit_r <= '0;
      end else if (I_CE) begin
         opto_s1_r        <= I_OPTO;
         opto_input_bit_r <= opto_s1_r;
      end
   end

   logic [NUM_FLAGS-1:0] flags_cur;
   always_comb begin
      flags_cur                            = '0;
      flags_cur[F_UV_A]                    = I_VA_MAG < uv_pickup_level_r;
      flags_cur[F_UV_B]                    = I_VB_MAG < uv_pickup_level_r;
      flags_cur[F_OV_B]                    = I_VB_MAG > ov_pickup_level_r;
      flags_cur[F_OPTO0 +: NUM_OPTO]       = opto_input_bit_r;
      flags_cur[F_TMR]                     = variable_timer_output_r;
      flags_cur[F_RES0 +: NUM_EQ]          = result_r;
      flags_cur[F_SOFT0 +: NUM_SOFT]       = soft_r;
   end

   // edges exist only per flag; a group has no literal to edge-detect
   wire [NUM_FLAGS-1:0] rise_lit = flags_cur & ~flags_prev_r;
   wire [NUM_FLAGS-1:0] fall_lit = ~flags_cur & flags_prev_r;
   wire lit_t           lits     = {fall_lit, rise_lit, ~flags_cur, flags_cur};

   // ---------------- equation units ----------------
   eval_if eqi [NUM_EQ] ();
   logic [NUM_EQ-1:0] eq_res;

   genvar e, w;
   generate
      for (e = 0; e < NUM_EQ; e++) begin : g_eq
         assign eqi[e].lit  = lits;
         assign eqi[e].ginv = ginv_r[e*NUM_GRP +: NUM_GRP];
         for (w = 0; w < EQ_WORDS; w++) begin : g_word
            assign eqi[e].cfg[w*32 +: 32] = cfg_mem[e*EQ_WORDS + w];
         end
         assign eq_res[e] = eqi[e].result;
         eq_unit u_eq (
            .eq (eqi[e].eval)
         );
      end
   endgenerate

   // ---------------- processing interval ----------------
   wire eval_en = ctrl_r[CTRL_EN_BIT];
   wire tick    = I_CE & eval_en & (tick_cnt_r == TICK_LAST);

   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         tick_cnt_r <= '0;
      end else if (I_CE & eval_en) begin
         tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? '0 : tick_cnt_r + 1'b1;
      end
   end

   // results and previous flags move together, once per interval
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         flags_prev_r <= '0;
         result_r     <= '0;
      end else if (tick) begin
         flags_prev_r <= flags_cur;
         result_r     <= eq_res;
      end
   end

   // ---------------- variable timer ----------------
   wire timer_in    = eq_res[EQ_TMR];
   wire pu_done     = tmr_cnt_r >= timer_pickup_delay_r;
   wire do_done     = tmr_cnt_r >= timer_dropout_delay_r;
   wire tmr_running = timer_in ^ variable_timer_output_r;

   // delays counted in processing intervals; zero delay acts on first tick
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         variable_timer_output_r <= 1'b0;
         tmr_cnt_r               <= '0;
      end else if (tick) begin
         if (!tmr_running) begin
            tmr_cnt_r <= '0;
         end else if (timer_in ? pu_done : do_done) begin
            variable_timer_output_r <= timer_in;
            tmr_cnt_r               <= '0;
         end else begin
            tmr_cnt_r <= tmr_cnt_r + 1'b1;
         end
      end
   end

   assign O_HRDATA    = hrdata_r;
   assign O_HREADYOUT = hreadyout_r;
   assign O_HRESP     = hresp_r;
   assign O_RESULT    = result_r;
   assign O_TIMER_OUT = variable_timer_output_r;
   assign O_FLAGS     = flags_prev_r;
endmodule : boolean_equation_evaluator

/* design/eval_pkg.sv */
package eval_pkg;
   // flag vector layout
   localparam int NUM_FLAGS  = 16;
   localparam int NUM_OPTO   = 4;
   localparam int NUM_SOFT   = 4;
   localparam int NUM_EQ     = 4;
   localparam int F_UV_A     = 0;
   localparam int F_UV_B     = 1;
   localparam int F_OV_B     = 2;
   localparam int F_OPTO0    = 3;
   localparam int F_TMR      = 7;
   localparam int F_RES0     = 8;
   localparam int F_SOFT0    = 12;
   // equation roles
   localparam int EQ_BRK     = 0;
   localparam int EQ_TMR     = 1;
   localparam int EQ_CONTACT = 2;
   localparam int EQ_SEAL    = 3;
   // equation shape: (g0 * g1) + g2, each group an OR of terms
   localparam int NUM_GRP    = 3;
   localparam int NUM_TERM   = 3;
   localparam int LIT_W      = 4 * NUM_FLAGS;
   localparam int EQ_WORDS   = NUM_GRP * NUM_TERM * LIT_W / 32;
   localparam int CFG_WORDS  = NUM_EQ * EQ_WORDS;
   localparam int MAG_W      = 16;
   localparam int CNT_W      = 16;
   // register byte addresses
   localparam logic [11:0] A_CTRL   = 12'h000;
   localparam logic [11:0] A_STATUS = 12'h004;
   localparam logic [11:0] A_UV_PU  = 12'h008;
   localparam logic [11:0] A_OV_PU  = 12'h00c;
   localparam logic [11:0] A_TPU    = 12'h010;
   localparam logic [11:0] A_TDO    = 12'h014;
   localparam logic [11:0] A_SOFT   = 12'h018;
   localparam logic [11:0] A_GINV   = 12'h01c;
   localparam logic [2:0]  TERM_PAGE = 3'h2;
   // fields
   localparam int CTRL_EN_BIT = 0;
   localparam int ST_RES_LSB  = 16;
   localparam int ST_TMR_BIT  = 20;
   // reset values
   localparam logic [31:0]            CTRL_RST  = 32'h0000_0001;
   localparam logic [MAG_W-1:0]       UV_PU_RST = 16'h0000;
   localparam logic [MAG_W-1:0]       OV_PU_RST = 16'hffff;
   localparam logic [CNT_W-1:0]       TPU_RST   = 16'h0000;
   localparam logic [CNT_W-1:0]       TDO_RST   = 16'h0000;
   localparam logic [NUM_EQ*NUM_GRP-1:0] GINV_RST = 12'h000;
   // processing interval
   localparam int PROC_INTERVAL_NS = 1000;
   localparam int CLK_MHZ          = 250;
   localparam int PROC_CYCLES      = PROC_INTERVAL_NS * CLK_MHZ / 1000;
   localparam int TICK_W           = 8;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(PROC_CYCLES - 1);
   // ahb
   localparam logic [1:0] HRESP_OKAY = 2'h0;

   typedef logic [LIT_W-1:0]                   lit_t;
   typedef logic [NUM_GRP*NUM_TERM*LIT_W-1:0]  eqcfg_t;
   typedef enum logic [0:0] {BUS_IDLE, BUS_DATA} bus_state_e;
endpackage : eval_pkg

/* design/eval_if.sv */
`timescale 1ns/1ps
interface eval_if;
   import eval_pkg::*;
   lit_t                lit;
   eqcfg_t              cfg;
   logic [NUM_GRP-1:0]  ginv;
   logic                result;
   modport src  (output lit, output cfg, output ginv, input result);
   modport eval (input lit, input cfg, input ginv, output result);
endinterface : eval_if

/* design/eq_unit.sv */
`timescale 1ns/1ps
module eq_unit (
   eval_if.eval  eq
);
   import eval_pkg::*;

   logic [NUM_GRP*NUM_TERM-1:0] term_hit;
   logic [NUM_GRP-1:0]          grp_or;
   logic [NUM_GRP-1:0]          grp_val;

   // empty term contributes nothing, so unused OR slots stay harmless
   genvar k;
   generate
      for (k = 0; k < NUM_GRP*NUM_TERM; k++) begin : g_term
         assign term_hit[k] = (|eq.cfg[k*LIT_W +: LIT_W]) &
                              (&(~eq.cfg[k*LIT_W +: LIT_W] | eq.lit));
      end
      for (k = 0; k < NUM_GRP; k++) begin : g_grp
         assign grp_or[k]  = |term_hit[k*NUM_TERM +: NUM_TERM];
         assign grp_val[k] = grp_or[k] ^ eq.ginv[k];
      end
   endgenerate

   // and binds tighter than or
   assign eq.result = (grp_val[0] & grp_val[1]) | grp_val[2];
endmodule : eq_unit

/* tb/boolean_equation_evaluator_asserts.sv */
`timescale 1ns/1ps
module boolean_equation_evaluator_asserts (
   input wire logic                          I_SYS_CLK,
   input wire logic                          I_RSTN,
   input wire logic                          I_CE,
   input wire logic                          I_HSEL,
   input wire logic [1:0]                    I_HTRANS,
   input wire logic                          I_HREADY,
   input wire logic [eval_pkg::NUM_OPTO-1:0] I_OPTO,
   input wire logic                          O_HREADYOUT,
   input wire logic [1:0]                    O_HRESP,
   input wire logic [eval_pkg::NUM_EQ-1:0]   O_RESULT,
   input wire logic                          O_TIMER_OUT,
   input wire logic [eval_pkg::NUM_FLAGS-1:0] O_FLAGS
);
   import eval_pkg::*;
   logic [NUM_OPTO-1:0] opto_prev_r;
   logic [3:0]          opto_age_r;
   logic [3:0]          opto_age_nxt;
   // age counts enabled cycles only, the synchroniser stalls with ce low
   assign opto_age_nxt = (I_OPTO != opto_prev_r) ? 4'h0 :
                         (opto_age_r == 4'hf) ? 4'hf : opto_age_r + {3'h0, I_CE};
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         opto_prev_r <= '0;
         opto_age_r  <= 4'h0;
      end else begin
         opto_prev_r <= I_OPTO;
         opto_age_r  <= opto_age_nxt;
      end
   end
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RSTN);
   sequence s_accept;
      I_HSEL && I_HTRANS[1] && I_HREADY;
   endsequence
   sequence s_one_wait;
      !O_HREADYOUT ##1 O_HREADYOUT;
   endsequence
   a_bus_wait: assert property (s_accept |=> s_one_wait)
      else $error("data phase length wrong");
   a_resp_okay: assert property (O_HRESP == HRESP_OKAY)
      else $error("response not okay");
   a_result_stand: assert property ($changed(O_RESULT) |=> $stable(O_RESULT)[*8])
      else $error("result changed within an interval");
   a_flags_stand: assert property ($changed(O_FLAGS) |=> $stable(O_FLAGS)[*8])
      else $error("flags changed within an interval");
   a_timer_stand: assert property ($changed(O_TIMER_OUT) |=> $stable(O_TIMER_OUT)[*8])
      else $error("timer output changed within an interval");
   a_ce_freeze: assert property (($changed(O_RESULT) || $changed(O_FLAGS)) |-> $past(I_CE))
      else $error("update without clock enable");
   a_timer_input: assert property ($rose(O_TIMER_OUT) |-> O_RESULT[EQ_TMR])
      else $error("timer rose with input false");
   a_prev_result: assert property ($changed(O_FLAGS) |-> O_FLAGS[F_RES0 +: NUM_EQ] == $past(O_RESULT))
      else $error("result flags not previous results");
   a_opto_flag: assert property (($changed(O_FLAGS) && opto_age_r > 4'h8)
      |-> O_FLAGS[F_OPTO0 +: NUM_OPTO] == I_OPTO)
      else $error("opto flag differs from settled input");
endmodule : boolean_equation_evaluator_asserts
bind boolean_equation_evaluator boolean_equation_evaluator_asserts u_chk (
   .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_CE(I_CE), .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS),
   .I_HREADY(I_HREADY), .I_OPTO(I_OPTO), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
   .O_RESULT(O_RESULT), .O_TIMER_OUT(O_TIMER_OUT), .O_FLAGS(O_FLAGS));

/* tb/boolean_equation_evaluator_tb_top.sv */
`timescale 1ns/1ps
module boolean_equation_evaluator_tb_top;
   import eval_pkg::*;
   logic        clk    = 1'b0;
   logic        rstn   = 1'b0;
   logic        ce     = 1'b1;
   logic        hsel   = 1'b0;
   logic [31:0] haddr  = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize  = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [15:0] va     = 16'h0;
   logic [15:0] vb     = 16'h0;
   logic [3:0]  opto   = 4'h0;
   logic [31:0] hrdata;
   logic        hready;
   logic        tmr_out;
   logic [1:0]  hresp;
   logic [3:0]  result;
   logic [15:0] flags;
   logic        rd_dp  = 1'b0;
   logic [63:0] q[$];
   logic [63:0] note;
   logic [7:0]  lfsr   = 8'h35;
   logic        seal   = 1'b0;
   logic        tin;
   logic [31:0] exp_st;
   int          errors = 0;
   int          n_tests = 0;
   int          k;
   logic [11:0] rst_a [8] = '{A_CTRL, A_UV_PU, A_OV_PU, A_TPU, A_TDO, A_SOFT, A_GINV, 12'h300};
   logic [31:0] rst_v [8] = '{CTRL_RST, 32'(UV_PU_RST), 32'(OV_PU_RST), 32'(TPU_RST),
                              32'(TDO_RST), 32'h0, 32'(GINV_RST), 32'h0};
   // breaker !opto0, timer !(uv_b+ov_b), contact rise+fall of soft0, seal (seal+o1)*o2
   int          t_idx [8] = '{12, 30, 32, 49, 51, 54, 56, 60};
   logic [31:0] t_val [8] = '{32'h0008_0000, 32'h2, 32'h4, 32'h1000, 32'h1000_0000, 32'h800, 32'h10, 32'h20};
   logic [15:0] va_t  [6] = '{16'h0fff, 16'h1000, 16'h0000, 16'hffff, 16'h1001, 16'h0ffe};
   logic [1:0]  o_t   [6] = '{2'h3, 2'h2, 2'h0, 2'h2, 2'h1, 2'h3};
   always #2 clk = ~clk;
   boolean_equation_evaluator dut (
      .I_SYS_CLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
      .O_HREADYOUT(hready), .O_HRESP(hresp), .I_VA_MAG(va), .I_VB_MAG(vb), .I_OPTO(opto),
      .O_RESULT(result), .O_TIMER_OUT(tmr_out), .O_FLAGS(flags));
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
      int n;
      n = 0;
      if (!w) q.push_back({m, d & m});
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {20'h0, a};
      hwrite <= w;
      do begin
         @(posedge clk);
         n++;
      end while (!hready && n < 50);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      do begin
         @(posedge clk);
         n++;
      end while (!hready && n < 50);
      if (n >= 50) check(32'h1, 32'h0);
   endtask : ahb
   task automatic stop_test();
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   // read data is compared at the edge that ends the data phase
   always @(posedge clk) begin
      if (rd_dp && hready) begin
         note = q.pop_front();
         check(hrdata & note[63:32], note[31:0]);
      end
      rd_dp <= (rd_dp && !hready) || (hsel && htrans[1] && hready && !hwrite);
   end
   initial begin
      #100000;
      check(32'h1, 32'h0);
      stop_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 8; i++) ahb(1'b0, rst_a[i], rst_v[i], 32'hffff_ffff);
      ahb(1'b1, A_STATUS, 32'hffff_ffff, 32'h0);
      ahb(1'b0, A_STATUS, 32'h0, 32'hffff_ffff);
      ahb(1'b1, A_UV_PU, 32'h1000, 32'h0);
      ahb(1'b1, A_OV_PU, 32'hc000, 32'h0);
      ahb(1'b1, A_GINV, 32'h20, 32'h0);
      for (int i = 0; i < 8; i++) ahb(1'b1, 12'h400 + 12'(4 * t_idx[i]), t_val[i], 32'h0);
      ahb(1'b0, A_GINV, 32'h20, 32'hffff_ffff);
      for (int i = 0; i < 6; i++) begin
         lfsr = lfsr_next(lfsr);
         va   <= va_t[i];
         vb   <= {lfsr, lfsr};
         opto <= {lfsr[7], o_t[i], lfsr[0]};
         repeat (3 * PROC_CYCLES) @(posedge clk);
         seal   = (seal | o_t[i][0]) & o_t[i][1];
         tin    = !((vb < 16'h1000) || (vb > 16'hc000));
         exp_st = {11'h0, tin, seal, 1'b0, tin, ~opto[0], 9'h0, opto, vb > 16'hc000, vb < 16'h1000, va < 16'h1000};
         ahb(1'b0, A_STATUS, exp_st, 32'h001f_007f);
         check({31'h0, tmr_out}, {31'h0, tin});
         check({30'h0, hresp}, {30'h0, HRESP_OKAY});
      end
      for (int i = 0; i < 2; i++) begin
         ahb(1'b1, A_SOFT, {31'h0, i == 0}, 32'h0);
         k = 0;
         while (result[EQ_CONTACT] !== 1'b1 && k < 600) begin
            @(posedge clk);
            k++;
         end
         k = 0;
         while (result[EQ_CONTACT] === 1'b1 && k < 600) begin
            @(posedge clk);
            k++;
         end
         check(32'(k), 32'(PROC_CYCLES));
      end
      // bus stays live while evaluation is frozen
      ce   <= 1'b0;
      opto <= ~opto;
      repeat (3 * PROC_CYCLES) @(posedge clk);
      ahb(1'b0, A_STATUS, exp_st, 32'h001f_007f);
      check({28'h0, flags[F_OPTO0 +: NUM_OPTO]}, {28'h0, ~opto});
      ce <= 1'b1;
      @(posedge clk);
      stop_test();
   end
endmodule : boolean_equation_evaluator_tb_top
